// ---- core/ces_pkg.sv ----
/*
 * Constants, state and cause types of the CPU exception sequencer.
 * Assumes a 32-bit program counter and 8-bit condition and extended registers.
 */
package ces_pkg;
    // ----------------------------------------
    // Status register fields
    // ----------------------------------------
    localparam int CCR_I_BIT = 7;
    localparam int EXR_T_BIT = 7;
    localparam int EXR_MASK_LSB = 0;
    localparam int EXR_MASK_W = 3;
    localparam logic [2:0] MASK_ALL = 3'h7;
    // ----------------------------------------
    // Interrupt control modes
    // ----------------------------------------
    localparam logic [1:0] INT_MODE_0 = 2'h0;
    localparam logic [1:0] INT_MODE_2 = 2'h2;
    // ----------------------------------------
    // Vector table offsets, plain defaults
    // ----------------------------------------
    localparam logic [31:0] VEC_OFF_ADDR_ERR = 32'h0000000C;
    localparam logic [31:0] VEC_OFF_NMI = 32'h0000001C;
    localparam logic [31:0] VEC_OFF_TRAP0 = 32'h00000020;
    localparam logic [31:0] VEC_OFF_SLEEP = 32'h00000030;
    localparam logic [31:0] VEC_OFF_ILLEGAL = 32'h00000034;
    localparam logic [31:0] VEC_OFF_SLOT = 32'h00000038;
    localparam int VEC_ENTRY_SHIFT = 2;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PUSH_PC = 3'h1,
        ST_PUSH_SR = 3'h3,
        ST_FETCH = 3'h2,
        ST_JUMP = 3'h6
    } ces_state_t;
    typedef enum logic [2:0] {
        C_ADDR_ERR = 3'h0,
        C_NMI = 3'h1,
        C_IRQ = 3'h2,
        C_TRAP = 3'h3,
        C_SLEEP = 3'h4,
        C_ILLEGAL = 3'h5,
        C_SLOT = 3'h6
    } ces_cause_t;
endpackage : ces_pkg

// ---- core/ces_vec_if.sv ----
/*
 * Carrier between the sequencer and its vector address generator.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/100ps
interface ces_vec_if;
    import ces_pkg::*;
    ces_cause_t cause;
    logic [1:0] trap_num;
    logic [15:0] irq_off;
    logic [31:0] vector_base_reg;
    logic [31:0] addr;
    modport seq (output cause, output trap_num, output irq_off, output vector_base_reg, input addr);
    modport gen (input cause, input trap_num, input irq_off, input vector_base_reg, output addr);
endinterface : ces_vec_if

// ---- core/ces_vec_gen.sv ----
/*
 * Vector table entry address generator.
 * Assumes the cause and operands stay stable while the address is used.
 */
`timescale 1ns/100ps
module ces_vec_gen (
    ces_vec_if.gen vif
);
    import ces_pkg::*;

    // ----------------------------------------
    // Offset lookup
    // ----------------------------------------
    function automatic logic [31:0] ces_vec_offset(input ces_cause_t c, input logic [1:0] n,
                                                   input logic [15:0] ioff);
        logic [31:0] o;
        o = VEC_OFF_ILLEGAL;
        case (c)
            C_ADDR_ERR: o = VEC_OFF_ADDR_ERR;
            C_NMI: o = VEC_OFF_NMI;
            C_IRQ: o = {16'h0000, ioff};
            C_TRAP: o = VEC_OFF_TRAP0 + ({30'h00000000, n} << VEC_ENTRY_SHIFT);
            C_SLEEP: o = VEC_OFF_SLEEP;
            C_SLOT: o = VEC_OFF_SLOT;
            default: o = VEC_OFF_ILLEGAL;
        endcase
        return o;
    endfunction : ces_vec_offset

    // Address error entry ignores the base so a corrupt base cannot recurse
    always_comb begin
        if (vif.cause == C_ADDR_ERR) begin
            vif.addr = ces_vec_offset(vif.cause, vif.trap_num, vif.irq_off); // RQ19
        end else begin
            vif.addr = vif.vector_base_reg + ces_vec_offset(vif.cause, vif.trap_num, vif.irq_off); // RQ19
        end
    end
endmodule : ces_vec_gen

// ---- core/ces_sequencer.sv ----
/*
 * CPU exception sequencer: address error, interrupt, trap, sleep and
 * illegal instruction entry. Stacks PC and status, updates the masks,
 * fetches the vector and halts the transfer engines on address error.
 * Assumes the pipeline, bus unit and interrupt controller share ref_clk_i,
 * hold their requests until taken, and acknowledge stack and vector cycles.
 */
// Functional notes
// (RQ1) Address error entry waits for the bus cycle end and instruction completion.
// (RQ2) Every entry stacks PC, CONDITION_CODE_REG, EXTENDED_STATUS_REG, updates masks, clears T in mode 2, fetches vector.
// (RQ3) New address errors are ignored while address error entry is running.
// (RQ4) Odd stack pointer during address error entry makes stacked values undefined.
// (RQ5) Address error sets the transfer controller error flag.
// (RQ6) Address error sets the error flag of DMA channel 0.
// (RQ7) Address error clears transfer enable of every DMA channel.
// (RQ8) Address error sets I; mode 2 also clears T and sets mask to 7.
// (RQ9) Interrupt sources: one NMI, twelve pins, peripherals via the controller.
// (RQ10) Two control modes; maskable sources carry one of eight levels.
// (RQ11) Each interrupt source supplies its own vector table offset.
// (RQ12) Trap always raises an exception; vector 0 to 3 from the code.
// (RQ13) Trap and illegal set I; mode 2 clears T, mask unchanged.
// (RQ14) Sleep traps when standby select is 0 and sleep exception enable is 1.
// (RQ15) Sleep exception waits until the CPU regains the bus.
// (RQ16) Sleep exception sets I; mode 2 also clears T and sets mask to 7.
// (RQ17) Undefined operation codes raise a general illegal instruction exception.
// (RQ18) Long or PC-changing delay slot instructions raise a slot illegal exception.
// (RQ19) Reset and address error vectors use the offset alone, others add base.
// (RQ20) Mode 0 gates with I; mode 2 with the level mask and source level.
// (RQ21) Status bits not listed as changed keep their prior value.
// (RQ22) Reset overrides everything and halts all processing.
`timescale 1ns/100ps
module ces_sequencer (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [31:0] pc_i,
    input wire logic [7:0] condition_code_reg_i,
    input wire logic [7:0] extended_status_reg_i,
    input wire logic [31:0] sp_i,
    input wire logic [31:0] vector_base_reg_i,
    input wire logic [1:0] int_mode_i,
    input wire logic standby_select_bit_i,
    input wire logic sleep_exception_enable_bit_i,
    input wire logic addr_err_i,
    input wire logic bus_cycle_done_i,
    input wire logic instr_done_i,
    input wire logic nmi_req_i,
    input wire logic irq_req_i,
    input wire logic [2:0] irq_level_i,
    input wire logic [15:0] irq_offset_i,
    input wire logic trap_exec_i,
    input wire logic [1:0] trap_num_i,
    input wire logic sleep_exec_i,
    input wire logic cpu_has_bus_i,
    input wire logic undef_op_i,
    input wire logic slot_violation_i,
    input wire logic push_ack_i,
    input wire logic vec_ack_i,
    input wire logic [31:0] vec_data_i,
    output logic busy_o,
    output logic irq_ack_o,
    output logic push_o,
    output logic [31:0] push_data_o,
    output logic stack_undef_o,
    output logic vec_rd_o,
    output logic [31:0] vec_addr_o,
    output logic pc_load_o,
    output logic [31:0] new_pc_o,
    output logic status_wr_o,
    output logic [7:0] condition_code_reg_o,
    output logic [7:0] extended_status_reg_o,
    output logic transfer_ctrl_err_set_o,
    output logic dma0_err_set_o,
    output logic dma_te_clr_all_o,
    output logic sleep_enter_o
);
    import ces_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        ces_state_t st;
        ces_cause_t cause;
        logic [1:0] trap_num;
        logic [15:0] irq_off;
        logic [2:0] irq_lvl;
        logic ae_pend;
        logic ae_bus_done;
        logic sl_pend;
        logic busy;
        logic irq_ack;
        logic push;
        logic [31:0] push_data;
        logic stack_undef;
        logic vec_rd;
        logic [31:0] vec_addr;
        logic pc_load;
        logic [31:0] new_pc;
        logic status_wr;
        logic [7:0] condition_code_reg;
        logic [7:0] extended_status_reg;
        logic dtc_err;
        logic dma0_err;
        logic te_clr;
        logic sleep_enter;
    } ces_regs_t;

    ces_regs_t r;
    ces_regs_t next_r;
    ces_vec_if vif ();
    logic irq_ok;
    logic ae_new;

    ces_vec_gen u_vec_gen (
        .vif(vif)
    );

    assign vif.cause = r.cause;
    assign vif.trap_num = r.trap_num;
    assign vif.irq_off = r.irq_off;
    assign vif.vector_base_reg = vector_base_reg_i;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Reserved mode codes behave as mode 0
    function automatic logic ces_is_mode2(input logic [1:0] m);
        return m == INT_MODE_2;
    endfunction : ces_is_mode2

    // Blocked while address error entry runs, so stacking cannot recurse
    assign ae_new = addr_err_i && !(r.busy && r.cause == C_ADDR_ERR); // RQ3

    // ----------------------------------------
    // Interrupt gating
    // ----------------------------------------
    always_comb begin
        if (ces_is_mode2(int_mode_i)) begin
            irq_ok = irq_req_i && (irq_level_i >
                     extended_status_reg_i[EXR_MASK_LSB +: EXR_MASK_W]); // RQ20 RQ10
        end else begin
            irq_ok = irq_req_i && !condition_code_reg_i[CCR_I_BIT]; // RQ20
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        next_r = r;
        next_r.irq_ack = 1'b0;
        next_r.pc_load = 1'b0;
        next_r.status_wr = 1'b0;
        next_r.dtc_err = 1'b0;
        next_r.dma0_err = 1'b0;
        next_r.te_clr = 1'b0;
        next_r.sleep_enter = 1'b0;
        // Error waits here until its bus cycle and instruction are done
        if (ae_new) begin
            next_r.ae_pend = 1'b1; // RQ3
        end
        if ((r.ae_pend || ae_new) && bus_cycle_done_i) begin
            next_r.ae_bus_done = 1'b1; // RQ1
        end
        case (r.st)
            ST_IDLE: begin
                if (r.ae_pend && r.ae_bus_done && instr_done_i) begin
                    next_r.cause = C_ADDR_ERR; // RQ1
                    // A fresh error in the take cycle stays pending: set wins
                    next_r.ae_pend = ae_new; // RQ3
                    next_r.ae_bus_done = ae_new && bus_cycle_done_i; // RQ1
                    next_r.dtc_err = 1'b1; // RQ5
                    next_r.dma0_err = 1'b1; // RQ6
                    next_r.te_clr = 1'b1; // RQ7
                    next_r.st = ST_PUSH_PC;
                end else if (r.sl_pend) begin
                    // Taken only once the other master has left the bus
                    if (cpu_has_bus_i) begin
                        next_r.sl_pend = 1'b0;
                        next_r.cause = C_SLEEP; // RQ15
                        next_r.st = ST_PUSH_PC;
                    end
                end else if (nmi_req_i) begin
                    next_r.cause = C_NMI; // RQ9
                    next_r.irq_ack = 1'b1;
                    next_r.irq_lvl = MASK_ALL;
                    next_r.st = ST_PUSH_PC;
                end else if (irq_ok) begin
                    next_r.cause = C_IRQ; // RQ9
                    next_r.irq_off = irq_offset_i; // RQ11
                    // Level kept here so a later change cannot alter the new mask
                    next_r.irq_lvl = irq_level_i;
                    next_r.irq_ack = 1'b1;
                    next_r.st = ST_PUSH_PC;
                end else if (trap_exec_i) begin
                    next_r.cause = C_TRAP; // RQ12
                    next_r.trap_num = trap_num_i; // RQ12
                    next_r.st = ST_PUSH_PC;
                end else if (undef_op_i) begin
                    next_r.cause = C_ILLEGAL; // RQ17
                    next_r.st = ST_PUSH_PC;
                end else if (slot_violation_i) begin
                    next_r.cause = C_SLOT; // RQ18
                    next_r.st = ST_PUSH_PC;
                end else if (sleep_exec_i) begin
                    if (!standby_select_bit_i && sleep_exception_enable_bit_i) begin
                        if (cpu_has_bus_i) begin
                            next_r.cause = C_SLEEP; // RQ14
                            next_r.st = ST_PUSH_PC;
                        end else begin
                            next_r.sl_pend = 1'b1; // RQ15
                        end
                    end else begin
                        next_r.sleep_enter = 1'b1; // RQ14
                    end
                end
                if (next_r.st == ST_PUSH_PC) begin
                    next_r.busy = 1'b1;
                    next_r.push = 1'b1; // RQ2
                    next_r.push_data = pc_i; // RQ2
                    // Odd stack pointer: stacked words carry no defined meaning
                    next_r.stack_undef = (next_r.cause == C_ADDR_ERR) && sp_i[0]; // RQ4
                end
            end
            ST_PUSH_PC: begin
                // Status word uses the live registers at the first ack
                if (push_ack_i) begin
                    next_r.push_data = {16'h0000, extended_status_reg_i,
                                        condition_code_reg_i}; // RQ2
                    next_r.st = ST_PUSH_SR;
                end
            end
            ST_PUSH_SR: begin
                if (push_ack_i) begin
                    next_r.push = 1'b0;
                    next_r.stack_undef = 1'b0;
                    next_r.vec_rd = 1'b1; // RQ2
                    // Base read late, so a base change during stacking still counts
                    next_r.vec_addr = vif.addr; // RQ19
                    next_r.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                // No timeout: the bus unit must answer every vector read
                if (vec_ack_i) begin
                    next_r.vec_rd = 1'b0;
                    next_r.new_pc = vec_data_i; // RQ2
                    next_r.st = ST_JUMP;
                end
            end
            ST_JUMP: begin
                // Untouched bits keep their value
                next_r.condition_code_reg = condition_code_reg_i; // RQ21
                next_r.extended_status_reg = extended_status_reg_i; // RQ21
                next_r.condition_code_reg[CCR_I_BIT] = 1'b1; // RQ8 RQ13 RQ16
                if (ces_is_mode2(int_mode_i)) begin
                    next_r.extended_status_reg[EXR_T_BIT] = 1'b0; // RQ2 RQ8 RQ13 RQ16
                    if (r.cause == C_ADDR_ERR || r.cause == C_SLEEP) begin
                        next_r.extended_status_reg[EXR_MASK_LSB +: EXR_MASK_W] = MASK_ALL; // RQ8 RQ16
                    end else if (r.cause == C_IRQ || r.cause == C_NMI) begin
                        next_r.extended_status_reg[EXR_MASK_LSB +: EXR_MASK_W] = r.irq_lvl;
                    end
                end
                next_r.status_wr = 1'b1; // RQ2
                next_r.pc_load = 1'b1; // RQ2
                next_r.busy = 1'b0;
                next_r.st = ST_IDLE;
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
    end

    // Reset wins over every pending exception
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0; // RQ22
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Every output is a flop of the state struct
    assign busy_o = r.busy;
    assign irq_ack_o = r.irq_ack;
    assign push_o = r.push;
    assign push_data_o = r.push_data;
    assign stack_undef_o = r.stack_undef;
    assign vec_rd_o = r.vec_rd;
    assign vec_addr_o = r.vec_addr;
    assign pc_load_o = r.pc_load;
    assign new_pc_o = r.new_pc;
    assign status_wr_o = r.status_wr;
    assign condition_code_reg_o = r.condition_code_reg;
    assign extended_status_reg_o = r.extended_status_reg;
    assign transfer_ctrl_err_set_o = r.dtc_err;
    assign dma0_err_set_o = r.dma0_err;
    assign dma_te_clr_all_o = r.te_clr;
    assign sleep_enter_o = r.sleep_enter;
endmodule : ces_sequencer

// ---- verification/ces_bus_partner.sv ----
/* Stack and vector bus model for the exception sequencer.
   Assumes one clock; acks are one-cycle pulses. */
`timescale 1ns/100ps
module ces_bus_partner (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic slow_i,
    input wire logic push_i,
    input wire logic vec_rd_i,
    input wire logic [31:0] vec_addr_i,
    output logic push_ack_o,
    output logic vec_ack_o,
    output logic [31:0] vec_data_o
);
    int wait_cnt;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            push_ack_o <= 1'b0;
            vec_ack_o <= 1'b0;
            vec_data_o <= 32'h0;
            wait_cnt <= 0;
        end else begin
            push_ack_o <= 1'b0;
            vec_ack_o <= 1'b0;
            // Idle data toggles, so no stale word looks valid
            vec_data_o <= ~vec_data_o;
            if ((push_i || vec_rd_i) && !push_ack_o && !vec_ack_o) begin
                if (wait_cnt < (slow_i ? 3 : 0)) begin
                    wait_cnt <= wait_cnt + 1;
                end else begin
                    wait_cnt <= 0;
                    push_ack_o <= push_i;
                    vec_ack_o <= vec_rd_i;
                    vec_data_o <= vec_addr_i ^ 32'h5A5A0000;
                end
            end
        end
    end
endmodule : ces_bus_partner

// ---- verification/ces_sequencer_asserts.sv ----
/* Port checker of the exception sequencer, bound below.
   Assumes status inputs stay stable during an entry. */
`timescale 1ns/100ps
module ces_sequencer_asserts
    import ces_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [31:0] pc_i,
    input wire logic [7:0] extended_status_reg_i,
    input wire logic [1:0] int_mode_i,
    input wire logic push_ack_i,
    input wire logic busy_o,
    input wire logic push_o,
    input wire logic [31:0] push_data_o,
    input wire logic stack_undef_o,
    input wire logic vec_rd_o,
    input wire logic pc_load_o,
    input wire logic status_wr_o,
    input wire logic [7:0] condition_code_reg_o,
    input wire logic [7:0] extended_status_reg_o,
    input wire logic transfer_ctrl_err_set_o,
    input wire logic dma0_err_set_o,
    input wire logic dma_te_clr_all_o,
    input wire logic sleep_enter_o,
    input wire logic irq_ack_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_HALT: assert property (transfer_ctrl_err_set_o |-> dma0_err_set_o && dma_te_clr_all_o
        && $rose(busy_o)) else $error("halt pulses apart");
    AST_ONE_HALT: assert property (dma_te_clr_all_o |=> !dma_te_clr_all_o [*4])
        else $error("second halt during entry");
    AST_PUSH_FIRST: assert property ($rose(busy_o) |-> push_o && !vec_rd_o)
        else $error("entry not started by push");
    AST_PC_WORD: assert property ($rose(push_o) && !stack_undef_o |-> push_data_o == $past(pc_i))
        else $error("first word not pc");
    AST_SR_WORD: assert property (push_o && push_ack_i && !stack_undef_o ##1 push_o
        |-> push_data_o[31:16] == 16'h0000) else $error("status word upper half");
    AST_LOAD_END: assert property (pc_load_o |-> status_wr_o && !busy_o && !vec_rd_o
        && $past(busy_o)) else $error("pc load outside entry");
    AST_I_SET: assert property (status_wr_o |-> condition_code_reg_o[CCR_I_BIT])
        else $error("mask bit not set");
    AST_T_CLR: assert property (status_wr_o && int_mode_i == INT_MODE_2
        |-> !extended_status_reg_o[EXR_T_BIT]) else $error("trace bit kept");
    AST_MODE0: assert property (status_wr_o && $past(int_mode_i) != INT_MODE_2
        |-> extended_status_reg_o == $past(extended_status_reg_i))
        else $error("mode 0 exr changed");
    AST_SLEEP: assert property (sleep_enter_o |-> !busy_o ##1 !busy_o)
        else $error("sleep entry with exception");
    COV_HALT: cover property (transfer_ctrl_err_set_o);
    COV_SLEEP: cover property (sleep_enter_o);
    COV_IRQ: cover property (irq_ack_o ##[1:40] pc_load_o);
endmodule : ces_sequencer_asserts
bind ces_sequencer ces_sequencer_asserts chk_u (.*);

// ---- verification/cpu_exception_sequencer_test.sv ----
/* Self-checking bench of the exception sequencer.
   Assumes the bus partner answers stack and vector cycles. */
`timescale 1ns/100ps
module cpu_exception_sequencer_test;
    import ces_pkg::*;
    logic ref_clk_i = 1'b0, resetn_i = 1'b0, slow = 1'b0;
    logic [31:0] pc_i = 32'h00001234, sp_i = 32'h0000FFF0, vector_base_reg_i = 32'h00010000;
    logic [7:0] condition_code_reg_i = 8'h05, extended_status_reg_i = 8'h83;
    logic [1:0] int_mode_i = 2'h0, trap_num_i = 2'h0;
    logic standby_select_bit_i = 1'b0, sleep_exception_enable_bit_i = 1'b1, addr_err_i = 1'b0;
    logic bus_cycle_done_i = 1'b1, instr_done_i = 1'b1, nmi_req_i = 1'b0, irq_req_i = 1'b0;
    logic [2:0] irq_level_i = 3'h5;
    logic [15:0] irq_offset_i = 16'h0140;
    logic trap_exec_i = 1'b0, sleep_exec_i = 1'b0, cpu_has_bus_i = 1'b1, undef_op_i = 1'b0;
    logic slot_violation_i = 1'b0, push_ack_i, vec_ack_i, undef_seen;
    logic [31:0] vec_data_i, push_data_o, vec_addr_o, new_pc_o, seen_vec;
    logic busy_o, irq_ack_o, push_o, stack_undef_o, vec_rd_o, pc_load_o, status_wr_o;
    logic transfer_ctrl_err_set_o, dma0_err_set_o, dma_te_clr_all_o, sleep_enter_o;
    logic [7:0] condition_code_reg_o, extended_status_reg_o;
    logic [31:0] words [$];
    int errors = 0, checks_done = 0, halts, acks;
    ces_sequencer dut_u (.*);
    ces_bus_partner bus_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .slow_i(slow),
        .push_i(push_o), .vec_rd_i(vec_rd_o), .vec_addr_i(vec_addr_o),
        .push_ack_o(push_ack_i), .vec_ack_o(vec_ack_i), .vec_data_o(vec_data_i));
    initial forever #12.5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        if (push_o && push_ack_i) words.push_back(push_data_o);
        if (vec_rd_o) seen_vec = vec_addr_o;
        halts += transfer_ctrl_err_set_o + dma0_err_set_o + dma_te_clr_all_o;
        acks += irq_ack_o;
        undef_seen |= stack_undef_o;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task conclude;
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task idle_for(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            check("busy idle", busy_o, 1'b0);
        end
    endtask : idle_for
    // ----
    // One exception entry: 0 trap 1 addr 2 sleep 3 undef 4 slot 5 nmi 6 irq
    // ----
    task run(input int kind, input logic [31:0] expv, input int m);
        int i;
        logic [7:0] exr_e;
        words = {};
        halts = 0;
        acks = 0;
        undef_seen = 1'b0;
        case (kind)
            0: trap_exec_i <= 1'b1;
            1: begin
                addr_err_i <= 1'b1;
                instr_done_i <= 1'b0;
                idle_for(1);
                // One error event; the unfinished instruction delays entry
                addr_err_i <= 1'b0;
                idle_for(2);
                instr_done_i <= 1'b1;
            end
            2: begin
                sleep_exec_i <= 1'b1;
                cpu_has_bus_i <= 1'b0;
                @(posedge ref_clk_i);
                sleep_exec_i <= 1'b0;
                idle_for(3);
                cpu_has_bus_i <= 1'b1;
            end
            3: undef_op_i <= 1'b1;
            4: slot_violation_i <= 1'b1;
            5: nmi_req_i <= 1'b1;
            default: begin
                irq_req_i <= 1'b1;
                // Level 3 against mask 3, or I set in mode 0, must wait
                if (int_mode_i == INT_MODE_2) irq_level_i <= 3'h3;
                else condition_code_reg_i <= 8'h85;
                idle_for(3);
                irq_level_i <= 3'h5;
                condition_code_reg_i <= 8'h05;
            end
        endcase
        for (i = 0; i < 60 && pc_load_o !== 1'b1; i++) begin
            @(posedge ref_clk_i);
            if (busy_o === 1'b1) begin
                trap_exec_i <= 1'b0;
                undef_op_i <= 1'b0;
                slot_violation_i <= 1'b0;
                nmi_req_i <= 1'b0;
                irq_req_i <= 1'b0;
                // Late address error inside its own entry
                addr_err_i <= (kind == 1 && i == 2);
            end
        end
        check("pc load", pc_load_o, 1'b1);
        if (pc_load_o !== 1'b1) conclude();
        exr_e = extended_status_reg_i;
        if (int_mode_i == INT_MODE_2) begin
            exr_e[EXR_T_BIT] = 1'b0;
            if (m >= 0) exr_e[2:0] = m[2:0];
        end
        if (!(kind == 1 && sp_i[0])) begin
            check("push count", words.size(), 2);
            check("pc word", words[0], pc_i);
            check("sr word", words[1], {16'h0000, extended_status_reg_i, condition_code_reg_i});
        end
        check("vector", seen_vec, expv);
        check("new pc", new_pc_o, expv ^ 32'h5A5A0000);
        check("ccr", condition_code_reg_o, condition_code_reg_i | 8'h80);
        check("exr", extended_status_reg_o, exr_e);
        check("halts", halts, kind == 1 ? 3 : 0);
        check("irq ack", acks, kind >= 5);
        check("stack undef", undef_seen, kind == 1 && sp_i[0]);
        idle_for(4);
    endtask : run
    initial begin
        repeat (12) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        for (int md = 0; md < 2; md++) begin
            int_mode_i <= md ? INT_MODE_2 : INT_MODE_0;
            sp_i <= md ? 32'h0000FFF1 : 32'h0000FFF0;
            @(posedge ref_clk_i);
            for (int n = 0; n < 4; n++) begin
                trap_num_i <= n[1:0];
                slow <= n[0];
                run(0, vector_base_reg_i + VEC_OFF_TRAP0 + 4 * n, -1);
            end
            run(1, VEC_OFF_ADDR_ERR, 7);
            run(2, vector_base_reg_i + VEC_OFF_SLEEP, 7);
            run(3, vector_base_reg_i + VEC_OFF_ILLEGAL, -1);
            run(4, vector_base_reg_i + VEC_OFF_SLOT, -1);
            run(5, vector_base_reg_i + VEC_OFF_NMI, 7);
            run(6, vector_base_reg_i + {16'h0000, irq_offset_i}, 5);
        end
        standby_select_bit_i <= 1'b1;
        sleep_exec_i <= 1'b1;
        @(posedge ref_clk_i);
        sleep_exec_i <= 1'b0;
        @(posedge ref_clk_i);
        check("sleep enter", sleep_enter_o, 1'b1);
        idle_for(2);
        // Reset in the middle of an entry drops it at once
        trap_exec_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        check("busy before reset", busy_o, 1'b1);
        trap_exec_i <= 1'b0;
        resetn_i <= 1'b0;
        @(posedge ref_clk_i);
        check("reset busy", busy_o, 1'b0);
        check("reset push", push_o, 1'b0);
        resetn_i <= 1'b1;
        idle_for(2);
        conclude();
    end
endmodule : cpu_exception_sequencer_test
